//--- inc/fmct_defs.svh
/*
  Offsets, field positions, reset values, frame codes and timing figures
  of the fax mode command and training block.
  Assumes a 32-bit Wishbone register bus and a 250 MHz core clock.
*/
`ifndef FMCT_DEFS_SVH
`define FMCT_DEFS_SVH
// ==========================================
// Register byte offsets
`define FMCT_A_CTRL 8'h00
`define FMCT_A_MODE 8'h04
`define FMCT_A_STAT 8'h08
`define FMCT_A_RXM 8'h0c
`define FMCT_A_RUN 8'h10
// ==========================================
// Mode register fields and reset values
`define FMCT_M_SCAN 2:0
`define FMCT_M_FSZ 3
`define FMCT_M_WSRC 4
`define FMCT_M_W1216 5
`define FMCT_M_W864 6
`define FMCT_M_WID 8:7
`define FMCT_M_RATE 10:9
`define FMCT_MODE_RST 11'h000
`define FMCT_RUN_RST 16'h0960
// ==========================================
// Identification fields, first bit sent is bit 7
`define FMCT_ID_CMD 8'h41
`define FMCT_ID_CFR 8'h21
`define FMCT_ID_FTT 8'h22
`define FMCT_ID_KEEP 8'h7f
`define FMCT_ID_LEN 6'h08
`define FMCT_FRM_LEN 6'h38
// ==========================================
// Recording widths in picture elements
`define FMCT_W_1728 12'h6c0
`define FMCT_W_2432 12'h980
`define FMCT_W_2048 12'h800
`define FMCT_W_1216 12'h4c0
`define FMCT_W_864 12'h360
// ==========================================
// Timing
`define FMCT_TCF_MS 1500
`define FMCT_CLK_KHZ 250000
`endif

//--- inc/fmct_pkg.sv
/*
  Types of the fax mode command and training block.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package fmct_pkg;
  // ==========================================
  // Training sequencer states
  typedef enum logic [2:0] {
    FMCT_IDLE = 3'h0,
    FMCT_WAIT_TRAIN = 3'h1,
    FMCT_TCF = 3'h2,
    FMCT_REPLY = 3'h3,
    FMCT_TRAIN2 = 3'h4
  } fmct_seq_t;
endpackage : fmct_pkg

//--- logic/fmct_zero_run.sv
/*
  Zero-run detector for the training check sequence.
  Assumes bits arrive with a one-cycle valid strobe, synchronous to clk_i.
*/
`timescale 1ns/1ps
module fmct_zero_run #(
  parameter int unsigned W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic clr_i,
  input wire logic en_i,
  input wire logic [W-1:0] need_i,
  // Bit stream
  input wire logic bit_i,
  input wire logic valid_i,
  // Result
  output logic hit_o
);
  logic [W-1:0] cnt, next_cnt;
  logic next_hit;

  // ==========================================
  // Run counter
  always_comb begin
    next_cnt = cnt;
    next_hit = hit_o;
    if (clr_i) begin
      next_cnt = '0;
      next_hit = 1'h0;
    end else if (en_i && valid_i) begin
      if (bit_i) begin
        next_cnt = '0;
      end else begin
        if (cnt != {W{1'h1}}) begin
          next_cnt = cnt + 1'h1;
        end
        if (cnt + 1'h1 >= need_i) begin
          next_hit = 1'h1;
        end
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cnt <= '0;
      hit_o <= 1'h0;
    end else begin
      cnt <= next_cnt;
      hit_o <= next_hit;
    end
  end

  a_run_one_breaks: assert property (@(posedge clk_i) disable iff (rst_i)
    (en_i && valid_i && bit_i && !clr_i) |=> (cnt == '0))
    else $error("Run counter not cleared by a one bit");
endmodule : fmct_zero_run

//--- logic/fmct_top.sv
/*
  Fax mode command frame builder and interpreter with training check
  sequencer, reached over a classic Wishbone slave.
  Assumes a modem front end that moves control bits at 300 bit/s over a
  valid/ready bit port, marks received frame starts, flags training
  patterns and delivers high-speed data bits with a valid strobe.
*/
// How it works
// - Command ID fixed, first bit don't-care
// - Bits 21-23 encode minimum scan time
// - Halved-time scan codes banned in command
// - Bit 28 picks 256 or 64 octets
// - Bit 33 picks width source
// - Bits 34,35 narrow widths; 36,37 invalid
// - Standard setting: bits 41,45 set
// - Extend bits set, unused modes cleared
// - Equalizer adapts during first training
// - Good check answers with confirmation frame
// - Bad check answers with failure frame
// - Second training re-adapts equalizer
// - Control frames use 300 bit/s channel
// - Frame is ID octet plus data
`timescale 1ns/1ps
`include "fmct_defs.svh"
module fmct_top #(
  parameter int unsigned TCF_CYC = `FMCT_TCF_MS * `FMCT_CLK_KHZ,
  parameter int unsigned RUN_W = 16
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_i,
  input wire logic [3:0] wb_sel_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Control frame channel
  output logic ctl_tx_bit_o,
  output logic ctl_tx_valid_o,
  input wire logic ctl_tx_ready_i,
  input wire logic ctl_rx_sof_i,
  input wire logic ctl_rx_bit_i,
  input wire logic ctl_rx_valid_i,
  // High-speed data channel
  input wire logic train_i,
  input wire logic dat_bit_i,
  input wire logic dat_valid_i,
  output logic eq_adapt_o,
  // Status
  output fmct_pkg::fmct_seq_t state_o
);
  import fmct_pkg::*;

  if (TCF_CYC < 2 || RUN_W < 8 || RUN_W > 16) begin : g_chk
    $error("fmct_top: unsupported parameter values");
  end

  // ==========================================
  // Helpers
  function automatic logic [7:0] fmct_rev8(input logic [7:0] v);
    logic [7:0] r;
    r = '0;
    for (int i = 0; i < 8; i++) begin
      r[i] = v[7-i];
    end
    return r;
  endfunction : fmct_rev8

  function automatic logic fmct_scan_ok(input logic [2:0] c);
    return (c == 3'h0) || (c == 3'h1) || (c == 3'h2) || (c == 3'h4) || (c == 3'h7);
  endfunction : fmct_scan_ok

  function automatic logic [7:0] fmct_scan_ms(input logic [2:0] c);
    case (c)
      3'h0: return 8'h14;
      3'h1: return 8'h28;
      3'h2: return 8'h0a;
      3'h4: return 8'h05;
      default: return 8'h00;
    endcase
  endfunction : fmct_scan_ms

  // Returns invalid flag above the width in elements
  function automatic logic [12:0] fmct_width(input logic src, input logic [1:0] wid,
                                             input logic w1216, input logic w864);
    if (!src) begin
      case (wid)
        2'h0: return {1'h0, `FMCT_W_1728};
        2'h1: return {1'h0, `FMCT_W_2432};
        2'h2: return {1'h0, `FMCT_W_2048};
        default: return {1'h1, `FMCT_W_1728};
      endcase
    end else if (w1216 && w864) begin
      return {1'h1, `FMCT_W_1728};
    end else if (w1216) begin
      return {1'h0, `FMCT_W_1216};
    end else if (w864) begin
      return {1'h0, `FMCT_W_864};
    end else begin
      return {1'h0, `FMCT_W_1728};
    end
  endfunction : fmct_width

  function automatic logic [31:0] fmct_merge(input logic [31:0] o, input logic [31:0] n,
                                             input logic [3:0] s);
    logic [31:0] r;
    r = o;
    for (int i = 0; i < 4; i++) begin
      if (s[i]) begin
        r[i*8 +: 8] = n[i*8 +: 8];
      end
    end
    return r;
  endfunction : fmct_merge

  // ==========================================
  // Declarations
  logic ack, next_ack;
  logic [31:0] dat, next_dat;
  logic send, next_send;
  logic rx_en, next_rx_en;
  logic [10:0] mode, next_mode;
  logic [4:0] stk, next_stk;
  logic [15:0] run_req, next_run;
  logic [55:0] tsh, next_tsh;
  logic [5:0] tcnt, next_tcnt;
  logic [55:0] rsh, next_rsh;
  logic [5:0] rcnt, next_rcnt;
  logic rlive, next_rlive;
  logic rdone, next_rdone;
  logic [24:0] rxm, next_rxm;
  fmct_seq_t seq, next_seq;
  logic [31:0] timer, next_timer;
  logic pass, next_pass;
  logic train_q, next_eq;
  logic zclr, zhit;
  logic bus_req, tx_busy, load_reply, send_take, cmd_ok, load_cmd;
  logic [48:1] cmd_d;
  logic [12:0] cmd_wid, rwid;
  logic [48:1] rd;
  logic [2:0] rscan;
  logic rx_ok, ev_frm, ev_bad, ev_cerr, ev_cfr, ev_ftt;
  logic [4:0] stk_set;

  assign bus_req = wb_cyc_i & wb_stb_i & ~ack;
  assign wb_ack_o = ack;
  assign wb_dat_o = dat;
  assign state_o = seq;

  // ==========================================
  // Command frame assembly
  assign cmd_wid = fmct_width(mode[`FMCT_M_WSRC], mode[`FMCT_M_WID], mode[`FMCT_M_W1216], mode[`FMCT_M_W864]);
  assign cmd_ok = fmct_scan_ok(mode[`FMCT_M_SCAN]) && !cmd_wid[12];

  always_comb begin
    cmd_d = '0;
    cmd_d[10] = 1'h1;
    cmd_d[11] = mode[10];
    cmd_d[12] = mode[9];
    cmd_d[17] = mode[8];
    cmd_d[18] = mode[7];
    cmd_d[21] = mode[2];
    cmd_d[22] = mode[1];
    cmd_d[23] = mode[0];
    cmd_d[24] = 1'h1;
    cmd_d[28] = mode[`FMCT_M_FSZ];
    cmd_d[32] = 1'h1;
    cmd_d[33] = mode[`FMCT_M_WSRC];
    cmd_d[34] = mode[`FMCT_M_W1216];
    cmd_d[35] = mode[`FMCT_M_W864];
    cmd_d[40] = 1'h1;
    cmd_d[41] = 1'h1;
    cmd_d[45] = 1'h1;
  end

  // ==========================================
  // Control frame transmitter, least significant bit first
  assign tx_busy = (tcnt != 6'h00);
  assign load_reply = (seq == FMCT_REPLY) && !tx_busy;
  assign send_take = send && !tx_busy && !load_reply;
  assign load_cmd = send_take && cmd_ok;
  assign ctl_tx_valid_o = tx_busy;
  assign ctl_tx_bit_o = tsh[0];

  always_comb begin
    next_tsh = tsh;
    next_tcnt = tcnt;
    if (load_reply) begin
      next_tsh = {48'h0, fmct_rev8(pass ? `FMCT_ID_CFR : `FMCT_ID_FTT)};
      next_tcnt = `FMCT_ID_LEN;
    end else if (load_cmd) begin
      next_tsh = {cmd_d, fmct_rev8(`FMCT_ID_CMD)};
      next_tcnt = `FMCT_FRM_LEN;
    end else if (tx_busy && ctl_tx_ready_i) begin
      next_tsh = {1'h0, tsh[55:1]};
      next_tcnt = tcnt - 6'h01;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      tsh <= '0;
      tcnt <= '0;
    end else begin
      tsh <= next_tsh;
      tcnt <= next_tcnt;
    end
  end

  // ==========================================
  // Control frame receiver and command decode
  assign rd = rsh[55:8];
  assign rscan = {rd[21], rd[22], rd[23]};
  assign rwid = fmct_width(rd[33], {rd[17], rd[18]}, rd[34], rd[35]);
  assign rx_ok = fmct_scan_ok(rscan) && !rwid[12] && !rd[36] && !rd[37];
  assign ev_frm = rdone && rx_ok;
  assign ev_bad = rdone && !rx_ok;

  always_comb begin
    next_rsh = rsh;
    next_rcnt = rcnt;
    next_rlive = rlive;
    next_rdone = 1'h0;
    next_rxm = rxm;
    if (!rx_en) begin
      next_rlive = 1'h0;
    end else if (ctl_rx_sof_i) begin
      next_rlive = 1'h1;
      next_rcnt = '0;
    end else if (ctl_rx_valid_i && rlive) begin
      next_rsh = {ctl_rx_bit_i, rsh[55:1]};
      next_rcnt = rcnt + 6'h01;
      if (rcnt == `FMCT_ID_LEN - 6'h01 &&
          (fmct_rev8(next_rsh[55:48]) & `FMCT_ID_KEEP) != (`FMCT_ID_CMD & `FMCT_ID_KEEP)) begin
        next_rlive = 1'h0;
      end
      if (rcnt == `FMCT_FRM_LEN - 6'h01) begin
        next_rlive = 1'h0;
        next_rdone = 1'h1;
      end
    end
    if (ev_frm) begin
      next_rxm = {rwid[12], fmct_scan_ms(rscan), rwid[11:0], rd[28], rscan};
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rsh <= '0;
      rcnt <= '0;
      rlive <= 1'h0;
      rdone <= 1'h0;
      rxm <= '0;
    end else begin
      rsh <= next_rsh;
      rcnt <= next_rcnt;
      rlive <= next_rlive;
      rdone <= next_rdone;
      rxm <= next_rxm;
    end
  end

  // ==========================================
  // Training and training check sequencer
  fmct_zero_run #(
    .W(RUN_W)
  ) u_zero_run (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .clr_i(zclr),
    .en_i(seq == FMCT_TCF),
    .need_i(run_req[RUN_W-1:0]),
    .bit_i(dat_bit_i),
    .valid_i(dat_valid_i),
    .hit_o(zhit)
  );

  assign ev_cfr = load_reply && pass;
  assign ev_ftt = load_reply && !pass;

  always_comb begin
    next_seq = seq;
    next_timer = timer;
    next_pass = pass;
    zclr = 1'h0;
    next_eq = ((seq == FMCT_WAIT_TRAIN) || (seq == FMCT_TRAIN2)) && train_i;
    case (seq)
      FMCT_IDLE: begin
        next_timer = '0;
      end
      FMCT_WAIT_TRAIN: begin
        if (train_q && !train_i) begin
          next_seq = FMCT_TCF;
          next_timer = '0;
          zclr = 1'h1;
        end
      end
      FMCT_TCF: begin
        next_timer = timer + 32'h1;
        if (timer == 32'(TCF_CYC - 1)) begin
          next_seq = FMCT_REPLY;
          next_pass = zhit;
        end
      end
      FMCT_REPLY: begin
        if (load_reply) begin
          next_seq = pass ? FMCT_TRAIN2 : FMCT_WAIT_TRAIN;
        end
      end
      FMCT_TRAIN2: begin
        if (train_q && !train_i) begin
          next_seq = FMCT_IDLE;
        end
      end
      default: begin
        next_seq = FMCT_IDLE;
      end
    endcase
    if (ev_frm) begin
      next_seq = FMCT_WAIT_TRAIN;
    end
    if (!rx_en) begin
      next_seq = FMCT_IDLE;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      seq <= FMCT_IDLE;
      timer <= '0;
      pass <= 1'h0;
      train_q <= 1'h0;
      eq_adapt_o <= 1'h0;
    end else begin
      seq <= next_seq;
      timer <= next_timer;
      pass <= next_pass;
      train_q <= train_i;
      eq_adapt_o <= next_eq;
    end
  end

  // ==========================================
  // Wishbone register file
  assign ev_cerr = send_take && !cmd_ok;
  assign stk_set = {ev_ftt, ev_cfr, ev_cerr, ev_bad, ev_frm};

  always_comb begin
    logic [31:0] cur;
    logic [31:0] w;
    cur = 32'h0;
    w = 32'h0;
    case (wb_adr_i)
      `FMCT_A_CTRL: cur = {30'h0, rx_en, send};
      `FMCT_A_MODE: cur = {21'h0, mode};
      `FMCT_A_STAT: cur = {19'h0, stk, 3'h0, tx_busy, 1'h0, seq};
      `FMCT_A_RXM: cur = {7'h0, rxm};
      `FMCT_A_RUN: cur = {16'h0, run_req};
      default: cur = 32'h0;
    endcase
    w = fmct_merge(cur, wb_dat_i, wb_sel_i);
    next_ack = bus_req;
    next_dat = (bus_req && !wb_we_i) ? cur : 32'h0;
    next_send = send && !send_take;
    next_rx_en = rx_en;
    next_mode = mode;
    next_run = run_req;
    next_stk = stk | stk_set;
    if (bus_req && wb_we_i) begin
      case (wb_adr_i)
        `FMCT_A_CTRL: begin
          next_rx_en = w[1];
          if (w[0]) begin
            next_send = 1'h1;
          end
        end
        `FMCT_A_MODE: next_mode = w[10:0];
        `FMCT_A_STAT: next_stk = (stk & ~w[12:8]) | stk_set;
        `FMCT_A_RUN: next_run = w[15:0];
        default: next_mode = mode;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack <= 1'h0;
      dat <= 32'h0;
      send <= 1'h0;
      rx_en <= 1'h0;
      mode <= `FMCT_MODE_RST;
      stk <= '0;
      run_req <= `FMCT_RUN_RST;
    end else begin
      ack <= next_ack;
      dat <= next_dat;
      send <= next_send;
      rx_en <= next_rx_en;
      mode <= next_mode;
      stk <= next_stk;
      run_req <= next_run;
    end
  end

  // ==========================================
  // Checks
  a_cmd_id_field: assert property (@(posedge clk_i) disable iff (rst_i)
    load_cmd |=> (tsh[7:1] == 7'h41 && tcnt == 6'h38))
    else $error("Command frame ID wrong");
  a_scan_code_legal: assert property (@(posedge clk_i) disable iff (rst_i)
    load_cmd |=> fmct_scan_ok({tsh[28], tsh[29], tsh[30]}))
    else $error("Halved scan code in command frame");
  a_extend_bits: assert property (@(posedge clk_i) disable iff (rst_i)
    load_cmd |=> (tsh[31] && tsh[39] && tsh[47] && tsh[34:32] == 3'h0 && tsh[38:36] == 3'h0))
    else $error("Extend or unused mode bits wrong");
  a_std_setting: assert property (@(posedge clk_i) disable iff (rst_i)
    load_cmd |=> (tsh[48] && tsh[52] && tsh[51:49] == 3'h0 && tsh[55:53] == 3'h0))
    else $error("Standard setting octet wrong");
  a_width_invalid: assert property (@(posedge clk_i) disable iff (rst_i)
    load_cmd |=> (!tsh[43] && !tsh[44] && tsh[35] == $past(mode[`FMCT_M_FSZ])))
    else $error("Invalid width bits or frame size wrong");
  a_eq_first: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq == FMCT_WAIT_TRAIN && train_i && rx_en) |=> eq_adapt_o)
    else $error("Equalizer not adapting in first training");
  a_eq_second: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq == FMCT_TRAIN2 && train_i) |=> eq_adapt_o)
    else $error("Equalizer not adapting in second training");
  a_reply_cfr: assert property (@(posedge clk_i) disable iff (rst_i)
    (load_reply && pass) |=> (tsh[7:0] == 8'h84 && tcnt == 6'h08 && stk[3]))
    else $error("Confirmation frame wrong");
  a_reply_ftt: assert property (@(posedge clk_i) disable iff (rst_i)
    (load_reply && !pass) |=> (tsh[7:0] == 8'h44 && tcnt == 6'h08 && stk[4]))
    else $error("Failure frame wrong");
  a_check_verdict: assert property (@(posedge clk_i) disable iff (rst_i)
    (seq == FMCT_TCF && rx_en && !ev_frm && timer == 32'(TCF_CYC - 1))
      |=> (seq == FMCT_REPLY && pass == $past(zhit)))
    else $error("Training check verdict wrong");
endmodule : fmct_top

//--- verif/fmct_remote.sv
/*
  Remote terminal model: takes the block's control bits, sends frames,
  training and check bits. Assumes one clock shared with the block.
*/
`timescale 1ns/1ps
module fmct_remote (
  // Clock
  input wire logic clk_i,
  // Control bits from the block
  input wire logic tx_bit_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o = 1'b0,
  // Control bits to the block
  output logic sof_o = 1'b0,
  output logic bit_o,
  output logic valid_o = 1'b0,
  // Training and check bits
  output logic train_o = 1'b0,
  output logic dat_bit_o,
  output logic dat_valid_o = 1'b0
);
  logic slow = 1'b0;
  logic tick = 1'b0;
  logic cb = 1'b0;
  logic db = 1'b0;
  logic got[$];
  // ==========================================
  // Released lines toggle every cycle
  assign bit_o = valid_o ? cb : tick;
  assign dat_bit_o = dat_valid_o ? db : tick;
  always @(posedge clk_i) begin
    tick <= ~tick;
    tx_ready_o <= slow ? ~tx_ready_o : 1'b1;
    if (tx_valid_i && tx_ready_o) begin
      got.push_back(tx_bit_i);
    end
  end
  // ==========================================
  // Frame, training and check senders
  task automatic send(input logic [55:0] f);
    @(posedge clk_i);
    sof_o <= 1'b1;
    for (int i = 55; i >= 0; i--) begin
      @(posedge clk_i);
      sof_o <= 1'b0;
      valid_o <= 1'b1;
      cb <= f[i];
    end
    @(posedge clk_i);
    valid_o <= 1'b0;
  endtask : send
  task automatic train(input int n);
    @(posedge clk_i);
    train_o <= 1'b1;
    repeat (n) @(posedge clk_i);
    train_o <= 1'b0;
  endtask : train
  task automatic check(input int n, input logic bad);
    for (int i = 0; i < n; i++) begin
      @(posedge clk_i);
      dat_valid_o <= 1'b1;
      db <= bad && (i % 8 == 7);
    end
    @(posedge clk_i);
    dat_valid_o <= 1'b0;
  endtask : check
endmodule : fmct_remote

//--- verif/fax_mode_command_and_training_test.sv
/*
  Self-checking bench of the mode command and training block.
  Assumes fmct_top, fmct_remote and a 250 MHz clock.
*/
`timescale 1ns/1ps
module fax_mode_command_and_training_test;
  import fmct_pkg::*;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic cyc = 1'b0;
  logic stb = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wd = 32'h0;
  logic [3:0] sel = 4'hf;
  logic [31:0] rd;
  logic ack, tb, tv, tr, sof, rb, rv, trn, db, dv, eq;
  fmct_seq_t st;
  logic [31:0] q;
  logic [31:0] seed = 32'h3a;
  logic [2:0] ok[5] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h7};
  logic [10:0] bad[5] = '{11'h003, 11'h006, 11'h005, 11'h180, 11'h070};
  int num_errors = 0;
  int tests_run = 0;
  int cycles = 0;
  // ==========================================
  // Block and remote terminal
  fmct_top #(.TCF_CYC(200), .RUN_W(16)) u_dut (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr),
    .wb_dat_i(wd), .wb_sel_i(sel), .wb_dat_o(rd), .wb_ack_o(ack), .ctl_tx_bit_o(tb),
    .ctl_tx_valid_o(tv), .ctl_tx_ready_i(tr), .ctl_rx_sof_i(sof), .ctl_rx_bit_i(rb),
    .ctl_rx_valid_i(rv), .train_i(trn), .dat_bit_i(db), .dat_valid_i(dv), .eq_adapt_o(eq),
    .state_o(st));
  fmct_remote u_remote (
    .clk_i(clk_i), .tx_bit_i(tb), .tx_valid_i(tv), .tx_ready_o(tr), .sof_o(sof), .bit_o(rb),
    .valid_o(rv), .train_o(trn), .dat_bit_o(db), .dat_valid_o(dv));
  // ==========================================
  // Clock and hang guard
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 20000) begin
      num_errors++;
      close_out();
    end
  end
  // ==========================================
  // Reference model
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction : rnd
  function automatic logic [55:0] frame(input logic [10:0] m);
    logic [48:1] d;
    logic [55:0] f;
    d = '0;
    {d[10], d[24], d[32], d[40], d[41], d[45]} = 6'h3f;
    {d[11], d[12], d[17], d[18]} = m[10:7];
    {d[21], d[22], d[23], d[28]} = {m[2:0], m[3]};
    {d[33], d[34], d[35]} = {m[4], m[5], m[6]};
    f[55:48] = 8'h41;
    for (int n = 1; n <= 48; n++) begin
      f[48 - n] = d[n];
    end
    return f;
  endfunction : frame
  function automatic logic [31:0] rxm(input logic [10:0] m);
    logic [7:0] ms;
    logic [11:0] w;
    case (m[2:0])
      3'h1: ms = 8'h28;
      3'h2: ms = 8'h0a;
      3'h4: ms = 8'h05;
      3'h7: ms = 8'h00;
      default: ms = 8'h14;
    endcase
    case (m[8:7])
      2'h1: w = 12'h980;
      2'h2: w = 12'h800;
      default: w = 12'h6c0;
    endcase
    return {8'h00, ms, w, m[3:0]};
  endfunction : rxm
  // ==========================================
  // Bus, capture and compare tasks
  task automatic chk(input string s, input logic [63:0] e, input logic [63:0] v);
    tests_run++;
    if (v !== e) begin
      num_errors++;
      $display("wrong value %s expected %h seen %h", s, e, v);
    end
  endtask : chk
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_i);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wd <= d;
    do begin
      @(posedge clk_i);
    end while (ack !== 1'b1);
    q = rd;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask : wb
  task automatic take(input int n, output logic [63:0] g);
    g = 64'h0;
    for (int i = 0; i < 3000 && u_remote.got.size() < n; i++) begin
      @(posedge clk_i);
    end
    repeat (8) @(posedge clk_i);
    chk("bit count", n, u_remote.got.size());
    foreach (u_remote.got[k]) begin
      g = {g[62:0], u_remote.got[k]};
    end
    u_remote.got.delete();
  endtask : take
  task automatic rx(input logic [55:0] f);
    u_remote.send(f);
    repeat (4) @(posedge clk_i);
  endtask : rx
  task automatic exch(input logic bad_tcf, input logic [7:0] id, input fmct_seq_t nxt);
    logic [63:0] g;
    fork
      u_remote.train(20);
      begin
        repeat (12) @(posedge clk_i);
        chk("eq adapt", 1'b1, eq);
      end
    join
    if (nxt != FMCT_IDLE) begin
      u_remote.check(230, bad_tcf);
      take(8, g);
      chk("reply frame", id, g);
    end
    repeat (4) @(posedge clk_i);
    chk("state", nxt, st);
    chk("eq idle", 1'b0, eq);
  endtask : exch
  task automatic close_out();
    $display("comparisons %0d mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : close_out
  // ==========================================
  // Main sequence
  initial begin
    logic [10:0] m;
    logic [55:0] f;
    logic [63:0] g;
    logic [31:0] r;
    repeat (10) @(posedge clk_i);
    rst_i <= 1'b0;
    wb(1'b0, 8'h04, 32'h0);
    chk("mode", 32'h0, q);
    wb(1'b0, 8'h10, 32'h0);
    chk("run", 32'h960, q);
    wb(1'b0, 8'h14, 32'h0);
    chk("unmapped", 32'h0, q);
    wb(1'b1, 8'h10, 32'h10);
    wb(1'b1, 8'h00, 32'h2);
    $display("register test done");
    foreach (ok[i]) begin
      r = rnd();
      m = {r[1:0], (r[3:2] == 2'h3) ? 2'h0 : r[3:2], r[4] & ~r[5], r[4] & r[5], r[4], r[6], ok[i]};
      u_remote.slow <= r[7];
      wb(1'b1, 8'h04, {21'h0, m});
      wb(1'b1, 8'h00, 32'h3);
      take(56, g);
      chk("command frame", frame(m), g);
    end
    $display("send test done");
    foreach (bad[i]) begin
      wb(1'b1, 8'h08, 32'h1f00);
      wb(1'b1, 8'h04, {21'h0, bad[i]});
      wb(1'b1, 8'h00, 32'h3);
      take(0, g);
      wb(1'b0, 8'h08, 32'h0);
      chk("refused", 1'b1, q[10]);
    end
    $display("refuse test done");
    m = 11'h48c;
    u_remote.slow <= 1'b0;
    f = frame(m);
    f[55] = 1'b1;
    rx(f);
    wb(1'b0, 8'h0c, 32'h0);
    chk("rx mode", rxm(m), q);
    chk("state", FMCT_WAIT_TRAIN, st);
    exch(1'b0, 8'h21, FMCT_TRAIN2);
    exch(1'b0, 8'h00, FMCT_IDLE);
    $display("train test done");
    rx(frame(m));
    exch(1'b1, 8'h22, FMCT_WAIT_TRAIN);
    m[10:9] = 2'h3;
    rx(frame(m));
    exch(1'b0, 8'h21, FMCT_TRAIN2);
    $display("fallback test done");
    f = frame(m);
    f[12] = 1'b1;
    wb(1'b1, 8'h08, 32'h1f00);
    wb(1'b0, 8'h08, 32'h0);
    chk("sticky clear", 5'h00, q[12:8]);
    rx(f);
    wb(1'b0, 8'h08, 32'h0);
    chk("bad frame", 1'b1, q[9]);
    $display("bad frame test done");
    close_out();
  end
endmodule : fax_mode_command_and_training_test
